/* ioxr_pin_world.sv */
// Pin-side partner model: resolves each pin from design drive and outside sources
`timescale 1ns/1ps

module ioxr_pin_world (
  // Clock
  input  wire logic        core_clk,
  // Design side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] pullup_on,
  // Outside drivers
  input  wire logic [15:0] ext_val,
  input  wire logic [15:0] ext_en,
  output logic      [15:0] pin_in
);
  logic [15:0] float_q = 16'h0000;

  // Floating pins wander each cycle so a stale level never passes
  always_ff @(posedge core_clk) begin
    float_q <= ~float_q;
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pullup_on[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

/* ioxr_pkg.sv */
// Register map, reset values and field positions of the I/O expander register bank
package ioxr_pkg;

  // Paired map (layout select clear), offsets as printed
  localparam logic [7:0] P_DIR_A   = 8'h00;
  localparam logic [7:0] P_DIR_B   = 8'h01;
  localparam logic [7:0] P_INV_A   = 8'h02;
  localparam logic [7:0] P_INV_B   = 8'h03;
  localparam logic [7:0] P_IEN_A   = 8'h04;
  localparam logic [7:0] P_IEN_B   = 8'h05;
  localparam logic [7:0] P_DEF_A   = 8'h06;
  localparam logic [7:0] P_DEF_B   = 8'h07;
  localparam logic [7:0] P_MODE_A  = 8'h80;
  localparam logic [7:0] P_MODE_B  = 8'h09;
  localparam logic [7:0] P_CFG     = 8'h0a;
  localparam logic [7:0] P_CFG_ALT = 8'h0b;
  localparam logic [7:0] P_PU_A    = 8'h0c;
  localparam logic [7:0] P_PU_B    = 8'h0d;
  localparam logic [7:0] P_FLAG_A  = 8'h0e;
  localparam logic [7:0] P_FLAG_B  = 8'h0f;
  localparam logic [7:0] P_SNAP_A  = 8'h10;
  localparam logic [7:0] P_SNAP_B  = 8'h11;
  localparam logic [7:0] P_PORT_A  = 8'h12;
  localparam logic [7:0] P_PORT_B  = 8'h13;
  localparam logic [7:0] P_LATCH_A = 8'h14;
  localparam logic [7:0] P_LATCH_B = 8'h15;

  // Split map: low nibble within a port; port B base sets address bit 4
  localparam logic [3:0] S_DIR   = 4'h0;
  localparam logic [3:0] S_INV   = 4'h1;
  localparam logic [3:0] S_IEN   = 4'h2;
  localparam logic [3:0] S_DEF   = 4'h3;
  localparam logic [3:0] S_MODE  = 4'h4;
  localparam logic [3:0] S_CFG   = 4'h5;
  localparam logic [3:0] S_PU    = 4'h6;
  localparam logic [3:0] S_FLAG  = 4'h7;
  localparam logic [3:0] S_SNAP  = 4'h8;
  localparam logic [3:0] S_PORT  = 4'h9;
  localparam logic [3:0] S_LATCH = 4'ha;
  localparam int         S_PORT_BIT = 4;

  // Reset values
  localparam logic [7:0] RST_DIR  = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // Configuration fields
  localparam int         CFG_BANK_BIT   = 7;
  localparam int         CFG_MIRROR_BIT = 6;
  localparam logic [7:0] CFG_WMASK      = 8'hfe;

  typedef enum {
    K_DIR, K_INV, K_IEN, K_DEF, K_MODE, K_CFG, K_PU, K_FLAG, K_SNAP, K_PORT, K_LATCH, K_NONE
  } ioxr_kind_t;

endpackage

/* ioxr_regbank.sv */
// Configuration and control register bank of a two-port 16-bit I/O expander
//
// How it works
// - Twenty-one registers: ten per port plus one shared configuration register.
// - Port B registers mirror port A layout and function, acting on port B.
// - Layout select clear: A and B registers paired at consecutive addresses 00-15, except port A mode at 80.
// - Paired map: configuration answers at 0A and 0B, one storage.
// - Set invert bit makes port value read the inverted pin level.
// - Change-interrupt enable bit per pin; all cleared at reset.
// - Input invert register is read/write, eight bits, resets to zero.
// - Port value reads pins, writes go to latch; latch reads latch only.
// - Input pins undriven; output pins driven from the output latch.
// - Compare mode set compares against default bit, clear against previous value.
`timescale 1ns/1ps

module ioxr_regbank
  import ioxr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Register access from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Pins, port B in the upper byte
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  output logic      [15:0] pullup_on,
  // Change events and configuration for the pin and serial logic
  output logic             irq_a,
  output logic             irq_b,
  output logic      [7:0]  cfg_out
);
  import ioxr_pkg::*;

  logic [7:0]  dir_q   [2];
  logic [7:0]  inv_q   [2];
  logic [7:0]  ien_q   [2];
  logic [7:0]  def_q   [2];
  logic [7:0]  mode_q  [2];
  logic [7:0]  pu_q    [2];
  logic [7:0]  flag_q  [2];
  logic [7:0]  snap_q  [2];
  logic [7:0]  latch_q [2];
  logic [7:0]  prev_q  [2];
  logic [7:0]  pv      [2];
  logic [7:0]  miss    [2];
  logic [7:0]  flag_d  [2];
  logic [7:0]  cfg_q;
  logic [15:0] sync1_q;
  logic [15:0] sync2_q;
  logic [15:0] oe_q;
  logic [15:0] pu_on_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rd_mux;
  logic [1:0]  irq_q;
  ioxr_kind_t  sel_kind;
  logic        sel_port;

  // Pins come from outside the clock domain
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Address decode; the map changes the cycle after the layout bit is written
  always_comb begin
    sel_kind = K_NONE;
    sel_port = 1'b0;
    if (cfg_q[CFG_BANK_BIT]) begin
      if (reg_addr[7:5] == 3'h0 && reg_addr[3:0] <= S_LATCH) begin
        sel_port = reg_addr[S_PORT_BIT];
        unique case (reg_addr[3:0])
          S_DIR:   sel_kind = K_DIR;
          S_INV:   sel_kind = K_INV;
          S_IEN:   sel_kind = K_IEN;
          S_DEF:   sel_kind = K_DEF;
          S_MODE:  sel_kind = K_MODE;
          S_CFG:   sel_kind = K_CFG;
          S_PU:    sel_kind = K_PU;
          S_FLAG:  sel_kind = K_FLAG;
          S_SNAP:  sel_kind = K_SNAP;
          S_PORT:  sel_kind = K_PORT;
          S_LATCH: sel_kind = K_LATCH;
          default: sel_kind = K_NONE;
        endcase
      end
    end else begin
      // Port A sits at the even address of each pair
      sel_port = reg_addr[0];
      unique case (reg_addr)
        P_DIR_A, P_DIR_B:     sel_kind = K_DIR;
        P_INV_A, P_INV_B:     sel_kind = K_INV;
        P_IEN_A, P_IEN_B:     sel_kind = K_IEN;
        P_DEF_A, P_DEF_B:     sel_kind = K_DEF;
        P_MODE_A, P_MODE_B:   sel_kind = K_MODE;
        P_CFG, P_CFG_ALT:     sel_kind = K_CFG;
        P_PU_A, P_PU_B:       sel_kind = K_PU;
        P_FLAG_A, P_FLAG_B:   sel_kind = K_FLAG;
        P_SNAP_A, P_SNAP_B:   sel_kind = K_SNAP;
        P_PORT_A, P_PORT_B:   sel_kind = K_PORT;
        P_LATCH_A, P_LATCH_B: sel_kind = K_LATCH;
        default:              sel_kind = K_NONE;
      endcase
    end
  end

  // Shared configuration; bit 0 is unimplemented and reads zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_q <= RST_ZERO;
    end else if (reg_wr_en && sel_kind == K_CFG) begin
      cfg_q <= reg_wdata & CFG_WMASK;
    end
  end

  // One copy of the per-port logic for each port
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic wr_here;
    logic clr_here;

    assign wr_here  = reg_wr_en && sel_port == 1'(p);
    assign clr_here = reg_rd_en && sel_port == 1'(p) &&
                      (sel_kind == K_SNAP || sel_kind == K_PORT);
    assign pv[p]    = sync2_q[p*8 +: 8] ^ inv_q[p];
    assign miss[p]  = ien_q[p] & ((mode_q[p] & (sync2_q[p*8 +: 8] ^ def_q[p])) |
                                  (~mode_q[p] & (sync2_q[p*8 +: 8] ^ prev_q[p])));
    // A new mismatch wins over the read that clears the flags
    assign flag_d[p] = (clr_here ? RST_ZERO : flag_q[p]) | miss[p];

    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        dir_q[p]  <= RST_DIR;
        inv_q[p]  <= RST_ZERO;
        ien_q[p]  <= RST_ZERO;
        def_q[p]  <= RST_ZERO;
        mode_q[p] <= RST_ZERO;
        pu_q[p]   <= RST_ZERO;
      end else if (wr_here) begin
        if (sel_kind == K_DIR) dir_q[p] <= reg_wdata;
        if (sel_kind == K_INV) inv_q[p] <= reg_wdata;
        if (sel_kind == K_IEN) ien_q[p] <= reg_wdata;
        if (sel_kind == K_DEF) def_q[p] <= reg_wdata;
        if (sel_kind == K_MODE) mode_q[p] <= reg_wdata;
        if (sel_kind == K_PU) pu_q[p] <= reg_wdata;
      end
    end

    // Writing the port value lands in the latch
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        latch_q[p] <= RST_ZERO;
      end else if (wr_here && (sel_kind == K_PORT || sel_kind == K_LATCH)) begin
        latch_q[p] <= reg_wdata;
      end
    end

    // Change detection; snapshot freezes on the first event until cleared
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        prev_q[p] <= RST_ZERO;
        flag_q[p] <= RST_ZERO;
        snap_q[p] <= RST_ZERO;
      end else begin
        prev_q[p] <= sync2_q[p*8 +: 8];
        flag_q[p] <= flag_d[p];
        // A clearing read in the same cycle as a new event still captures it
        if ((flag_q[p] == RST_ZERO || clr_here) && miss[p] != RST_ZERO) snap_q[p] <= pv[p];
      end
    end

    // Inputs undriven, outputs follow the latch; pull-ups only on inputs
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        oe_q[p*8 +: 8]    <= RST_ZERO;
        pu_on_q[p*8 +: 8] <= RST_ZERO;
      end else begin
        oe_q[p*8 +: 8]    <= ~dir_q[p];
        pu_on_q[p*8 +: 8] <= pu_q[p] & dir_q[p];
      end
    end
  end

  // Mirror joins both ports onto both event outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_q <= 2'b00;
    end else if (cfg_q[CFG_MIRROR_BIT]) begin
      irq_q <= {2{(|flag_q[0]) | (|flag_q[1])}};
    end else begin
      irq_q <= {|flag_q[1], |flag_q[0]};
    end
  end

  always_comb begin
    unique case (sel_kind)
      K_DIR:   rd_mux = dir_q[sel_port];
      K_INV:   rd_mux = inv_q[sel_port];
      K_IEN:   rd_mux = ien_q[sel_port];
      K_DEF:   rd_mux = def_q[sel_port];
      K_MODE:  rd_mux = mode_q[sel_port];
      K_CFG:   rd_mux = cfg_q;
      K_PU:    rd_mux = pu_q[sel_port];
      K_FLAG:  rd_mux = flag_q[sel_port];
      K_SNAP:  rd_mux = snap_q[sel_port];
      K_PORT:  rd_mux = pv[sel_port];
      K_LATCH: rd_mux = latch_q[sel_port];
      K_NONE:  rd_mux = RST_ZERO;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_q <= RST_ZERO;
    end else if (reg_rd_en) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;
  assign pin_out   = {latch_q[1], latch_q[0]};
  assign pin_oe    = oe_q;
  assign pullup_on = pu_on_q;
  assign irq_a     = irq_q[0];
  assign irq_b     = irq_q[1];
  assign cfg_out   = cfg_q;

  property p_dir_reset;
    @(posedge core_clk) !sys_rst && $past(sys_rst)
      |-> dir_q[0] == RST_DIR && dir_q[1] == RST_DIR && pin_oe == 16'h0000;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not all inputs after reset");

  property p_ien_reset;
    @(posedge core_clk) $past(sys_rst) && !sys_rst |-> ien_q[0] == 8'h00 && ien_q[1] == 8'h00;
  endproperty
  a_ien_reset: assert property (p_ien_reset) else $error("change enables not cleared");

  property p_inv_reset;
    @(posedge core_clk) $past(sys_rst) && !sys_rst |-> inv_q[0] == 8'h00 && inv_q[1] == 8'h00;
  endproperty
  a_inv_reset: assert property (p_inv_reset) else $error("invert register not zero");

  property p_port_read;
    @(posedge core_clk) disable iff (sys_rst)
      reg_rd_en && sel_kind == K_PORT && !sel_port
      |=> reg_rdata == ($past(sync2_q[7:0]) ^ $past(inv_q[0]));
  endproperty
  a_port_read: assert property (p_port_read) else $error("port read ignores invert");

  property p_cfg_alias;
    @(posedge core_clk) disable iff (sys_rst)
      reg_wr_en && !cfg_q[CFG_BANK_BIT] && reg_addr == P_CFG_ALT
      |=> cfg_q == ($past(reg_wdata) & 8'hfe);
  endproperty
  a_cfg_alias: assert property (p_cfg_alias) else $error("config alias write lost");

  property p_port_write;
    @(posedge core_clk) disable iff (sys_rst)
      reg_wr_en && sel_kind == K_PORT && sel_port |=> pin_out[15:8] == $past(reg_wdata);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port write missed latch");

  property p_oe_follow;
    @(posedge core_clk) disable iff (sys_rst)
      reg_wr_en && sel_kind == K_DIR && !sel_port ##1 !sys_rst
      |=> pin_oe[7:0] == ~$past(reg_wdata, 2);
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("drive enable not inverse of dir");

  property p_split_read;
    @(posedge core_clk) disable iff (sys_rst)
      reg_rd_en && cfg_q[CFG_BANK_BIT] && reg_addr == 8'h10 |=> reg_rdata == $past(dir_q[1]);
  endproperty
  a_split_read: assert property (p_split_read) else $error("split map port B dir wrong");

  property p_pair_read;
    @(posedge core_clk) disable iff (sys_rst)
      reg_rd_en && !cfg_q[CFG_BANK_BIT] && reg_addr == 8'h01 |=> reg_rdata == $past(dir_q[1]);
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("paired map port B dir wrong");

  property p_default_cmp;
    @(posedge core_clk) disable iff (sys_rst)
      ien_q[0][0] && mode_q[0][0] && (sync2_q[0] != def_q[0][0]) |=> flag_q[0][0] ##1 irq_a;
  endproperty
  a_default_cmp: assert property (p_default_cmp) else $error("default compare missed event");

  property p_ien_off;
    @(posedge core_clk) disable iff (sys_rst)
      ien_q[1] == RST_ZERO && flag_q[1] == RST_ZERO |=> flag_q[1] == RST_ZERO;
  endproperty
  a_ien_off: assert property (p_ien_off) else $error("flag set with enables clear");

endmodule

/* tb_top.sv */
// Self-checking bench for the I/O expander register bank
`timescale 1ns/1ps

module tb_top;
  import ioxr_pkg::*;
  localparam logic [7:0] RW_ADDR [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                          8'h07, 8'h09, 8'h0c, 8'h0d, 8'h14, 8'h15, 8'h80};
  logic        core_clk  = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr_en = 1'b0;
  logic        reg_rd_en = 1'b0;
  logic [15:0] ext_val   = 16'h0000;
  logic [15:0] ext_en    = 16'hffff;
  logic [15:0] lfsr_q    = 16'ha1b0;
  logic [7:0]  reg_rdata, cfg_out, v, inv_a, inv_b;
  logic [15:0] pin_in, pin_out, pin_oe, pullup_on;
  logic        irq_a, irq_b;
  logic [7:0]  mdl [0:255];
  int          error_cnt = 0;
  int          n_tests   = 0;

  always #2.5 core_clk = ~core_clk;

  ioxr_regbank ioxr_regbank_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .irq_a(irq_a), .irq_b(irq_b), .cfg_out(cfg_out));

  ioxr_pin_world ioxr_pin_world_inst (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    mdl[a] = d;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk(reg_rdata, exp);
  endtask

  // Bounded wait; a missing event ends the run early
  task automatic wait_irq;
    for (int i = 0; i < 8 && irq_a !== 1'b1; i++) @(negedge core_clk);
    chk({7'h00, irq_a}, 8'h01);
    if (irq_a !== 1'b1) stop_test();
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge core_clk);
    // Port value rows read pins, so they are left out here
    for (int a = 0; a < 22; a++) begin
      if (a != 18 && a != 19) rdc(8'(a), (a < 2) ? RST_DIR : RST_ZERO);
    end
    rdc(P_MODE_A, RST_ZERO);
    foreach (RW_ADDR[i]) begin
      v = rnd();
      wr(RW_ADDR[i], v);
    end
    foreach (RW_ADDR[i]) rdc(RW_ADDR[i], mdl[RW_ADDR[i]]);
    // Layout bit kept clear so the paired map stays in force; bit 0 must read zero
    v = rnd();
    wr(P_CFG, v & 8'h7f);
    rdc(P_CFG_ALT, v & 8'h7e);
    wr(P_CFG_ALT, 8'h00);
    rdc(P_CFG, 8'h00);
    wr(P_DIR_A, 8'hff);
    wr(P_DIR_B, 8'hff);
    inv_a = rnd();
    inv_b = rnd();
    wr(P_INV_A, inv_a);
    wr(P_INV_B, inv_b);
    v = rnd();
    ext_val = {lfsr_q[15:8], v};
    repeat (3) @(negedge core_clk);
    rdc(P_PORT_A, ext_val[7:0] ^ inv_a);
    rdc(P_PORT_B, ext_val[15:8] ^ inv_b);
    wr(P_DIR_A, 8'h00);
    v = rnd();
    wr(P_PORT_A, v);
    @(negedge core_clk);
    chk(pin_out[7:0], v);
    chk(pin_oe[7:0], 8'hff);
    chk(pin_oe[15:8], 8'h00);
    rdc(P_LATCH_A, v);
    repeat (2) @(negedge core_clk);
    rdc(P_PORT_A, v ^ inv_a);
    wr(P_CFG, 8'h80);
    chk(cfg_out, 8'h80);
    rdc(8'h10, mdl[P_DIR_B]);
    rdc(8'h1a, mdl[P_LATCH_B]);
    wr(8'h05, 8'h00);
    rdc(P_CFG, 8'h00);
    // Mid-run reset must undo the direction, drive enable, change enable, invert and snapshot values written so far
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    chk(pin_oe[7:0], 8'h00);
    rdc(P_DIR_A, RST_DIR);
    rdc(P_IEN_A, RST_ZERO);
    rdc(P_INV_B, RST_ZERO);
    rdc(P_SNAP_A, RST_ZERO);
    wr(P_INV_A, inv_a);
    wr(P_INV_B, inv_b);
    rdc(P_PORT_A, ext_val[7:0] ^ inv_a);
    rdc(P_PORT_B, ext_val[15:8] ^ inv_b);
    ext_val[1] = ~ext_val[1];
    repeat (4) @(negedge core_clk);
    chk({7'h00, irq_a}, 8'h00);
    wr(P_MODE_A, 8'h00);
    wr(P_IEN_A, 8'h01);
    ext_val[0] = ~ext_val[0];
    wait_irq();
    chk({7'h00, irq_b}, 8'h00);
    rdc(P_FLAG_A, 8'h01);
    rdc(P_SNAP_A, ext_val[7:0] ^ inv_a);
    rdc(P_PORT_A, ext_val[7:0] ^ inv_a);
    wr(P_DEF_A, {7'h00, ext_val[0]});
    wr(P_MODE_A, 8'h01);
    repeat (4) @(negedge core_clk);
    chk({7'h00, irq_a}, 8'h00);
    ext_val[0] = ~ext_val[0];
    wait_irq();
    // Mirror joins port A's standing event onto the port B output
    wr(P_CFG_ALT, 8'h40);
    chk(cfg_out, 8'h40);
    repeat (2) @(negedge core_clk);
    chk({7'h00, irq_b}, 8'h01);
    // Port B upper half driven low from the latch, lower half left to the pull-ups
    ext_en = 16'h00ff;
    wr(P_DIR_B, 8'h0f);
    wr(P_PU_B, 8'hff);
    repeat (2) @(negedge core_clk);
    chk(pullup_on[15:8], 8'h0f);
    rdc(P_PORT_B, 8'h0f ^ inv_b);
    stop_test();
  end
endmodule
